// >>> bench/ocal_core_sva.sv
// ocal_core_sva: port-level assertions for the optical sensor autocalibrator
`timescale 1ns/1ps
`default_nettype none
module ocal_core_sva
   import ocal_pkg::*;
(
   input wire logic               mclk,
   input wire logic               rst_b,
   input wire logic [LEVEL_W-1:0] sense_level,
   input wire ocal_retain_t       store_data,
   input wire logic               store_write,
   input wire logic [DRIVE_W-1:0] led_drive,
   input wire logic               trip_high,
   input wire logic               trip_low,
   input wire ocal_lights_t       lights,
   input wire ocal_state_t        cal_state
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   logic [2:0] n_flash; // success flashes in the current run

   // count success light rises; a restart clears it so aborted runs do not add up
   always_ff @(posedge mclk) begin
      if (!rst_b || cal_state == OCAL_RAMP) begin
         n_flash <= 3'h0;
      end else if ($rose(lights.cal_ok)) begin
         n_flash <= n_flash + 3'h1;
      end
   end

   // two settled cycles after reset, so the boot edge that forces zeros is skipped
   property p_trip_hi;
      rst_b && $past(rst_b) && $past(rst_b, 2) |-> trip_high == ($past(sense_level) > TRIP_HI_POINT);
   endproperty
   a_trip_hi: assert property (p_trip_hi) else $error("high trip wrong");
   property p_trip_lo;
      rst_b && $past(rst_b) && $past(rst_b, 2) |-> trip_low == ($past(sense_level) < TRIP_LO_POINT);
   endproperty
   a_trip_lo: assert property (p_trip_lo) else $error("low trip wrong");
   property p_lights_trip;
      $past(rst_b) |-> lights.above_hi == ($past(sense_level) > TRIP_HI_POINT)
         && lights.below_lo == ($past(sense_level) < TRIP_LO_POINT);
   endproperty
   a_lights_trip: assert property (p_lights_trip) else $error("trip lights differ");
   property p_restart;
      cal_state == OCAL_RAMP && $past(cal_state) != OCAL_SETTLE && $past(rst_b)
         |-> led_drive == DRIVE_ZERO && store_write && !store_data.valid;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not from zero");
   property p_settle_hold;
      cal_state == OCAL_SETTLE && $past(cal_state) == OCAL_SETTLE |-> $stable(led_drive);
   endproperty
   a_settle_hold: assert property (p_settle_hold) else $error("drive moved while settling");
   property p_frozen;
      cal_state inside {OCAL_FLASH, OCAL_LOCK, OCAL_FAIL} && $past(cal_state) == cal_state |-> $stable(led_drive);
   endproperty
   a_frozen: assert property (p_frozen) else $error("held drive moved");
   property p_target;
      cal_state == OCAL_FLASH && $past(cal_state) == OCAL_SETTLE |-> $past(sense_level) >= CAL_POINT;
   endproperty
   a_target: assert property (p_target) else $error("locked below target");
   property p_fail;
      cal_state == OCAL_FAIL && $past(cal_state) == OCAL_SETTLE |-> led_drive == DRIVE_CEILING ##1 lights.cal_fail;
   endproperty
   a_fail: assert property (p_fail) else $error("fail without ceiling or red");
   property p_three;
      cal_state == OCAL_LOCK && $past(cal_state) == OCAL_FLASH |-> n_flash == 3'h3;
   endproperty
   a_three: assert property (p_three) else $error("flash count wrong");
   property p_retain;
      cal_state == OCAL_LOCK && $past(cal_state) == OCAL_FLASH
         |-> ##[0:1] store_write && store_data == {1'b1, led_drive};
   endproperty
   a_retain: assert property (p_retain) else $error("lock not retained");

   c_lock: cover property (cal_state == OCAL_LOCK && $past(cal_state) == OCAL_FLASH);
   c_fail: cover property (cal_state == OCAL_FAIL && $past(cal_state) == OCAL_SETTLE);
   c_abort: cover property (cal_state == OCAL_RAMP && $past(cal_state) == OCAL_FLASH);
endmodule
`default_nettype wire

// >>> bench/ocal_sensor_model.sv
// ocal_sensor_model: behavioural LED and phototransistor pair
`timescale 1ns/1ps
`default_nettype none
module ocal_sensor_model
   import ocal_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic [DRIVE_W-1:0] led_drive,   // LED current code from the device
   input  wire logic [DRIVE_W-1:0] knee_drive,  // drive that lifts the level past target, 0 = blocked
   input  wire logic               force_en,    // bench overrides the optical level
   input  wire logic [LEVEL_W-1:0] force_level, // level used while overridden
   output logic      [LEVEL_W-1:0] sense_level  // converter code seen by the device
);
   // one cycle of optical and converter lag, so the device must settle before judging
   always_ff @(posedge mclk) begin
      if (force_en) begin
         sense_level <= force_level;
      end else if (knee_drive != 8'h00 && led_drive >= knee_drive) begin
         sense_level <= 8'h90; // enough light, just past the target
      end else begin
         sense_level <= 8'h20; // dark: too little drive or beam blocked
      end
   end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// tb_top: self-checking bench for the optical sensor autocalibrator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ocal_pkg::*;
   logic mclk = 1'b0;                  // 20 MHz clock
   logic rst_b = 1'b0;                 // synchronous reset
   logic cal_req_b = 1'b1;             // request pin, idle high
   ocal_retain_t stored = '0;          // non-volatile store contents
   ocal_retain_t saved = '0;           // last value written to the store
   logic [7:0] knee = 8'h06;           // sensor sensitivity
   logic force_en = 1'b0;              // level override
   logic [7:0] force_level = 8'h00;    // override value
   logic [7:0] sense_level;            // sensor output
   ocal_retain_t store_data;           // setting to retain
   logic store_write;                  // store strobe
   logic [7:0] led_drive;              // LED code
   logic trip_high;                    // high trip output
   logic trip_low;                     // low trip output
   ocal_lights_t lights;               // indicators
   ocal_state_t cal_state;             // device state
   int failures = 0;                   // mismatches
   int n_tests = 0;                    // comparisons
   int cycles = 0;                     // watchdog count
   int flashes = 0;                    // success flashes since cleared
   int starts = 0;                     // fresh calibration starts
   logic prev_ok = 1'b0;               // success light at last falling edge
   ocal_state_t prev_st = OCAL_IDLE;   // state at last falling edge
   logic [7:0] lv[7] = '{8'hab, 8'haa, 8'h80, 8'h55, 8'h54, 8'h00, 8'hff}; // trip boundaries

   always #25 mclk = ~mclk;

   // short counts keep the run small; the sequence lengths follow from them
   ocal_core #(.DEB_CYCLES(4), .HALF_CYCLES(5), .STEP_CYCLES(3)) ocal_core_inst (
      .mclk(mclk), .rst_b(rst_b), .cal_req_b(cal_req_b), .sense_level(sense_level), .stored(stored),
      .store_data(store_data), .store_write(store_write), .led_drive(led_drive), .trip_high(trip_high),
      .trip_low(trip_low), .lights(lights), .cal_state(cal_state));
   ocal_sensor_model ocal_sensor_model_inst (
      .mclk(mclk), .led_drive(led_drive), .knee_drive(knee), .force_en(force_en),
      .force_level(force_level), .sense_level(sense_level));

   // stand-in for the non-volatile store
   always @(posedge mclk) begin
      if (store_write === 1'b1) begin
         saved <= store_data;
      end
   end

   // counts on the falling edge, where outputs are settled; a run starting inside press is seen too
   always @(negedge mclk) begin
      if (lights.cal_ok === 1'b1 && prev_ok !== 1'b1) flashes++;
      if (cal_state === OCAL_RAMP && !(prev_st inside {OCAL_SETTLE, OCAL_RAMP})) starts++;
      prev_ok = lights.cal_ok;
      prev_st = cal_state;
   end

   // watchdog: a hang counts as a mismatch
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         close_out();
      end
   end

   task automatic close_out;
      if (failures == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [8:0] got, input logic [8:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_st(input ocal_state_t exp);
      n_tests++;
      if (cal_state !== exp) begin
         failures++;
         $display("mismatch %0t state got %h expected %h", $time, cal_state, exp);
      end
   endtask

   // power cycle: reset for 4 cycles with the store presenting nv
   task automatic do_reset(input ocal_retain_t nv);
      @(posedge mclk);
      rst_b <= 1'b0;
      stored <= nv;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
   endtask

   // ground the request pin for n_low edges, then let it go
   task automatic press(input int n_low);
      @(posedge mclk);
      cal_req_b <= 1'b0;
      repeat (n_low) @(posedge mclk);
      cal_req_b <= 1'b1;
   endtask

   // wait for a state within limit cycles, then judge it
   task automatic wait_st(input ocal_state_t st, input int limit);
      #1;
      for (int i = 0; i < limit && cal_state !== st; i++) begin
         @(posedge mclk);
         #1;
      end
      chk_st(st);
   endtask

   // a glitch shorter than the debounce must not start a run
   task automatic t_glitch;
      press(2);
      repeat (15) @(posedge mclk);
      #1;
      chk_st(OCAL_IDLE);
   endtask

   // pin held low a long time: one run, ramp to the knee, three flashes, retained
   task automatic t_cal_ok;
      knee <= 8'h06;
      press(40);
      wait_st(OCAL_LOCK, 400);
      chk_val({1'b0, led_drive}, 9'h006, "lock drive");
      chk_val(9'(starts), 9'h001, "runs per press");
      chk_val(9'(flashes), 9'h003, "flashes");
      chk_val({8'h00, lights.cal_fail}, 9'h000, "red light");
      repeat (2) @(posedge mclk);
      #1;
      chk_val(saved, 9'h106, "stored setting");
      knee <= 8'h00;
      repeat (10) @(posedge mclk);
      #1;
      chk_val({1'b0, led_drive}, 9'h006, "held drive");
   endtask

   // power loss: the retained setting returns without a request
   task automatic t_power;
      do_reset(saved);
      chk_st(OCAL_LOCK);
      chk_val({1'b0, led_drive}, 9'h006, "restored drive");
   endtask

   // trip outputs and lights across their boundaries, drive untouched
   task automatic t_trip;
      foreach (lv[i]) begin
         @(posedge mclk);
         force_en <= 1'b1;
         force_level <= lv[i];
         repeat (3) @(posedge mclk);
         #1;
         chk_val({8'h00, trip_high}, {8'h00, lv[i] > TRIP_HI_POINT}, "trip high");
         chk_val({8'h00, trip_low}, {8'h00, lv[i] < TRIP_LO_POINT}, "trip low");
         chk_val(9'(lights[1:0]), {7'h00, lv[i] > TRIP_HI_POINT, lv[i] < TRIP_LO_POINT}, "trip lights");
      end
      chk_val({1'b0, led_drive}, 9'h006, "drive after trips");
      force_en <= 1'b0;
   endtask

   // a request during the success flashes restarts from zero
   task automatic t_restart;
      knee <= 8'h03;
      press(6);
      wait_st(OCAL_FLASH, 200);
      repeat (3) @(posedge mclk);
      press(6);
      wait_st(OCAL_RAMP, 60);
      chk_val({1'b0, led_drive}, 9'h000, "restart drive");
      @(posedge mclk);
      #1;
      chk_val({8'h00, lights.cal_ok}, 9'h000, "flash aborted");
      flashes = 0;
      wait_st(OCAL_LOCK, 400);
      chk_val({1'b0, led_drive}, 9'h003, "relock drive");
      chk_val(9'(flashes), 9'h003, "relock flashes");
   endtask

   // blocked beam: ramp to the ceiling, red light, then a request clears it
   task automatic t_fail;
      knee <= 8'h00;
      press(6);
      wait_st(OCAL_FAIL, 1500);
      repeat (2) @(posedge mclk);
      #1;
      chk_val({1'b0, led_drive}, {1'b0, DRIVE_CEILING}, "fail drive");
      chk_val({7'h00, lights.cal_fail, lights.cal_ok}, 9'h002, "fail lights");
      press(6);
      wait_st(OCAL_RAMP, 60);
      repeat (2) @(posedge mclk);
      #1;
      chk_val({8'h00, lights.cal_fail}, 9'h000, "red cleared");
   endtask

   initial begin
      do_reset('0);
      chk_st(OCAL_IDLE);
      t_glitch();
      t_cal_ok();
      t_power();
      t_trip();
      t_restart();
      t_fail();
      close_out();
   end
endmodule

bind ocal_core ocal_core_sva ocal_core_sva_inst (
   .mclk(mclk), .rst_b(rst_b), .sense_level(sense_level), .store_data(store_data),
   .store_write(store_write), .led_drive(led_drive), .trip_high(trip_high), .trip_low(trip_low),
   .lights(lights), .cal_state(cal_state));
`default_nettype wire

// >>> hdl/ocal_core.sv
// ocal_core: top of the optical sensor autocalibrator
//
// Function
// - low pulse on request pin starts calibration
// - ramp LED drive from zero toward ceiling
// - half-supply level is the calibration target
// - flash green success light three times
// - hold found drive until next request
// - drive at ceiling without target lights red
// - high trip output set above two thirds
// - low trip output set below one third
// - locked drive survives power loss
// - blue light high trip, green low trip
// - request accepted in every state, restarts
//
// The sensed level arrives as a code from an converter on mclk; the drive
// output is a code for a current DAC where DRIVE_CEILING stands for 14 mA.
`timescale 1ns/1ps
`default_nettype none
module ocal_core
   import ocal_pkg::*;
#(
   parameter int unsigned DEB_CYCLES   = DEBOUNCE_CYCLES, // request debounce length
   parameter int unsigned HALF_CYCLES  = FLASH_CYCLES,    // success flash half period
   parameter int unsigned STEP_CYCLES  = SETTLE_CYCLES,   // settle wait per drive step
   parameter int unsigned CNT_W        = TIMER_W          // width of long timers
) (
   input  wire logic               mclk,        // 20 MHz system clock
   input  wire logic               rst_b,       // synchronous reset, active low
   input  wire logic               cal_req_b,   // calibration request pin, active low
   input  wire logic [LEVEL_W-1:0] sense_level, // phototransistor level code
   input  wire ocal_retain_t       stored,      // retained setting read at power-up
   output ocal_retain_t            store_data,  // setting to retain
   output logic                    store_write, // one-cycle write strobe for store_data
   output logic [DRIVE_W-1:0]      led_drive,   // LED current code
   output logic                    trip_high,   // high when level above upper point
   output logic                    trip_low,    // high when level below lower point
   output ocal_lights_t            lights,      // indicator lights
   output ocal_state_t             cal_state    // current calibration state
);
   // declarations
   logic                   req_pulse;     // one pulse per accepted request
   logic                   boot_pending;  // first cycle after reset release
   logic [CNT_W-1:0]       step_tmr;      // settle wait counter
   logic                   step_done;     // settle wait has elapsed
   logic                   hit_target;    // level at or above calibration point
   logic                   flash_start;   // starts the success flashes
   logic                   flash_light;   // flasher lamp
   logic                   flash_done;    // flasher finished
   logic                   fail_light;    // red lamp state
   ocal_state_t            next_state;    // state for the next cycle

   // request pin conditioning
   // the pin is asynchronous and mechanically noisy, so it is filtered
   // before anything in this module looks at it
   ocal_req_filter #(
      .DEB_CYCLES (DEB_CYCLES),
      .CNT_W      (CNT_W)
   ) u_req (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .pin_b      (cal_req_b),
      .fall_pulse (req_pulse)
   );

   // success flasher
   // a new request aborts a run in progress so the light never shows
   // flashes that belong to an abandoned calibration
   ocal_flasher #(
      .HALF_CYCLES (HALF_CYCLES),
      .CNT_W       (CNT_W)
   ) u_flash (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .start   (flash_start),
      .abort   (req_pulse),
      .flashes (FLASH_COUNT),
      .light   (flash_light),
      .done    (flash_done)
   );

   // target compare
   // the target is reached once the level climbs to half supply
   assign hit_target = (sense_level >= CAL_POINT);

   // settle wait ends on its last count
   assign step_done  = (step_tmr == CNT_W'(STEP_CYCLES - 1));

   // flashes start on the settle cycle that found the target
   assign flash_start = (cal_state == OCAL_SETTLE) && step_done && hit_target && !req_pulse;

   // power-up marker
   // the retained setting is a port, so it cannot be loaded under reset;
   // it is taken on the first clock after release instead
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         boot_pending <= 1'b1;
      end else begin
         boot_pending <= 1'b0;
      end
   end

   // next state
   always_comb begin
      next_state = cal_state;
      if (boot_pending) begin
         // resume a retained lock without recalibrating
         if (stored.valid) begin
            next_state = OCAL_LOCK;
         end else begin
            next_state = OCAL_IDLE;
         end
      end else if (req_pulse) begin
         // any state: a request restarts from zero drive
         next_state = OCAL_RAMP;
      end else begin
         case (cal_state)
            OCAL_IDLE: begin
               next_state = OCAL_IDLE;                           // wait for a request
            end
            OCAL_RAMP: begin
               next_state = OCAL_SETTLE;                         // let the optics follow
            end
            OCAL_SETTLE: begin
               if (step_done) begin
                  if (hit_target) begin
                     next_state = OCAL_FLASH;
                  end else if (led_drive == DRIVE_CEILING) begin
                     next_state = OCAL_FAIL;
                  end else begin
                     next_state = OCAL_RAMP;                     // one more step up
                  end
               end
            end
            OCAL_FLASH: begin
               if (flash_done) begin
                  next_state = OCAL_LOCK;
               end
            end
            OCAL_LOCK: begin
               next_state = OCAL_LOCK;
            end
            OCAL_FAIL: begin
               next_state = OCAL_FAIL;                           // red stays until a request
            end
            default: begin
               next_state = OCAL_IDLE;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cal_state <= OCAL_IDLE;
      end else begin
         cal_state <= next_state;
      end
   end

   // settle timer
   // runs only in the settle state and is cleared on every other state,
   // so each step gets its full wait
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         step_tmr <= '0;
      end else if (cal_state == OCAL_SETTLE && !step_done && !req_pulse) begin
         step_tmr <= step_tmr + 1'b1;
      end else begin
         step_tmr <= '0;
      end
   end

   // LED drive
   // the drive steps one code per settle period; a finer ramp costs time
   // per calibration but lands closer to the calibration point
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         led_drive <= DRIVE_ZERO;
      end else if (boot_pending) begin
         if (stored.valid) begin
            led_drive <= stored.code;
         end else begin
            led_drive <= DRIVE_ZERO;
         end
      end else if (req_pulse) begin
         led_drive <= DRIVE_ZERO;
      end else if (cal_state == OCAL_RAMP && led_drive != DRIVE_CEILING && led_drive != DRIVE_ZERO) begin
         led_drive <= led_drive + 8'h01;
      end else if (cal_state == OCAL_RAMP && led_drive == DRIVE_ZERO && step_tmr == '0 && !hit_target) begin
         led_drive <= 8'h01;                                     // leave zero once it was tried
      end
      // outside the ramp the code is simply held
   end

   // retained setting write
   // the store is written once, on entry to lock after a calibration;
   // a request first invalidates it so a power loss mid-run cannot
   // resume a half-finished setting
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         store_write <= 1'b0;
         store_data  <= '0;
      end else if (req_pulse && !boot_pending) begin
         store_write      <= 1'b1;
         store_data.valid <= 1'b0;
         store_data.code  <= DRIVE_ZERO;
      end else if (cal_state == OCAL_FLASH && flash_done) begin
         store_write      <= 1'b1;
         store_data.valid <= 1'b1;
         store_data.code  <= led_drive;
      end else begin
         store_write <= 1'b0;
      end
   end

   // failure light
   // stays on until a new request clears it
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         fail_light <= 1'b0;
      end else if (req_pulse) begin
         fail_light <= 1'b0;
      end else if (cal_state == OCAL_SETTLE && step_done && !hit_target && led_drive == DRIVE_CEILING) begin
         fail_light <= 1'b1;
      end
   end

   // logic trip outputs
   // plain comparisons with no hysteresis; the two points are far enough
   // apart that the outputs never chatter against each other
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         trip_high <= 1'b0;
         trip_low  <= 1'b0;
      end else begin
         trip_high <= (sense_level > TRIP_HI_POINT);
         trip_low  <= (sense_level < TRIP_LO_POINT);
      end
   end

   // indicator lights
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         lights <= '0;
      end else begin
         lights.cal_ok   <= flash_light;
         lights.cal_fail <= fail_light;
         lights.above_hi <= (sense_level > TRIP_HI_POINT);
         lights.below_lo <= (sense_level < TRIP_LO_POINT);
      end
   end
endmodule
`default_nettype wire

// >>> hdl/ocal_flasher.sv
// ocal_flasher: blinks a light a fixed number of times, then reports done
`timescale 1ns/1ps
`default_nettype none
module ocal_flasher
   import ocal_pkg::*;
#(
   parameter int unsigned HALF_CYCLES = FLASH_CYCLES,
   parameter int unsigned CNT_W       = TIMER_W
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       start,   // begin a flash run
   input  wire logic       abort,   // stop at once, light off
   input  wire logic [1:0] flashes, // number of on periods
   output logic            light,   // lamp drive
   output logic            done     // one cycle after the last off period
);
   logic             busy;          // run in progress
   logic [CNT_W-1:0] tmr;           // cycles in the current half period
   logic [1:0]       left;          // on periods still to show

   // half-period timer and flash sequencing
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         busy  <= 1'b0;
         light <= 1'b0;
         tmr   <= '0;
         left  <= 2'h0;
         done  <= 1'b0;
      end else if (abort) begin
         busy  <= 1'b0;
         light <= 1'b0;
         done  <= 1'b0;
      end else if (start) begin
         busy  <= 1'b1;
         light <= 1'b1;
         tmr   <= '0;
         left  <= flashes;
         done  <= 1'b0;
      end else if (busy && tmr == CNT_W'(HALF_CYCLES - 1)) begin
         tmr <= '0;
         if (light) begin
            light <= 1'b0;                       // end of an on period
            left  <= left - 2'h1;
         end else if (left == 2'h0) begin
            busy <= 1'b0;                        // last off period over
            done <= 1'b1;
         end else begin
            light <= 1'b1;                       // next flash
         end
      end else begin
         done <= 1'b0;
         if (busy) begin
            tmr <= tmr + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> hdl/ocal_req_filter.sv
// ocal_req_filter: synchroniser, debouncer and falling-edge pulse for the request pin
`timescale 1ns/1ps
`default_nettype none
module ocal_req_filter
   import ocal_pkg::*;
#(
   parameter int unsigned DEB_CYCLES = DEBOUNCE_CYCLES,
   parameter int unsigned CNT_W      = TIMER_W
) (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic pin_b,      // raw request pin, active low
   output logic      fall_pulse  // one cycle per accepted low pulse
);
   logic             sync_a;     // first stage, read only by sync_b
   logic             sync_b;     // second stage, safe to use
   logic             stable;     // debounced pin level
   logic [CNT_W-1:0] cnt;        // cycles the synced level differed

   // two-flop synchroniser, idles high like the pulled-up pin
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end else begin
         sync_a <= pin_b;
         sync_b <= sync_a;
      end
   end

   // debounce: a new level is accepted only after it held long enough
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt    <= '0;
         stable <= 1'b1;
      end else if (sync_b == stable) begin
         cnt <= '0;                                         // bounce resets the wait
      end else if (cnt == CNT_W'(DEB_CYCLES - 1)) begin
         cnt    <= '0;
         stable <= sync_b;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   // one pulse on each accepted high-to-low change, none while held low
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         fall_pulse <= 1'b0;
      end else begin
         fall_pulse <= stable && !sync_b && (cnt == CNT_W'(DEB_CYCLES - 1));
      end
   end
endmodule
`default_nettype wire

// >>> shared/ocal_pkg.sv
// ocal_pkg: shared constants and types for the optical sensor autocalibrator
package ocal_pkg;
   // clock rate, kept in kHz so the cycle products stay inside 32 bits
   localparam int unsigned CLK_KHZ         = 20000;
   // sensed level and drive code widths
   localparam int unsigned LEVEL_W         = 8;
   localparam int unsigned DRIVE_W         = 8;
   // calibration point: half of supply on the level scale
   localparam logic [7:0]  CAL_POINT       = 8'h80;
   // upper trip point, about two thirds of supply
   localparam logic [7:0]  TRIP_HI_POINT   = 8'haa;
   // lower trip point, about one third of supply
   localparam logic [7:0]  TRIP_LO_POINT   = 8'h55;
   // drive code that stands for 0 mA and for the 14 mA ceiling
   localparam int unsigned DRIVE_MIN_MA    = 0;
   localparam int unsigned DRIVE_MAX_MA    = 14;
   localparam logic [7:0]  DRIVE_ZERO      = 8'h00;
   localparam logic [7:0]  DRIVE_CEILING   = 8'hff;
   // number of success flashes
   localparam logic [1:0]  FLASH_COUNT     = 2'h3;
   // settling time after each drive step, least time so rounded up
   localparam int unsigned SETTLE_US       = 5;
   localparam int unsigned SETTLE_CYCLES   = (SETTLE_US * CLK_KHZ + 999) / 1000;
   // request debounce time
   localparam int unsigned DEBOUNCE_MS     = 10;
   localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;
   // half period of one success flash (on time equals off time)
   localparam int unsigned FLASH_HALF_MS   = 200;
   localparam int unsigned FLASH_CYCLES    = FLASH_HALF_MS * CLK_KHZ;
   // width of the long timers
   localparam int unsigned TIMER_W         = 23;

   // calibration state, gray along idle-ramp-settle-flash-lock
   typedef enum logic [2:0] {
      OCAL_IDLE   = 3'h0,
      OCAL_RAMP   = 3'h1,
      OCAL_SETTLE = 3'h3,
      OCAL_FLASH  = 3'h2,
      OCAL_LOCK   = 3'h6,
      OCAL_FAIL   = 3'h7
   } ocal_state_t;

   // indicator lights, all active high
   typedef struct packed {
      logic cal_ok;    // green success light
      logic cal_fail;  // red failure light
      logic above_hi;  // blue upper trip light
      logic below_lo;  // green lower trip light
   } ocal_lights_t;

   // retained drive setting, exchanged with the non-volatile store
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } ocal_retain_t;
endpackage
